// ===== include/wave_gen_pkg.sv
package wave_gen_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CON0 = 4'h0;
    localparam logic [3:0] ADDR_CON1 = 4'h1;
    localparam logic [3:0] ADDR_ISM = 4'h2;
    localparam logic [3:0] ADDR_DBR = 4'h3;
    localparam logic [3:0] ADDR_DBF = 4'h4;
    localparam logic [3:0] ADDR_STR = 4'h5;
    localparam logic [3:0] ADDR_AS0 = 4'h6;
    localparam logic [3:0] ADDR_AS1 = 4'h7;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // Field positions
    localparam int CON0_EN = 7;
    localparam int CON1_CS = 4;
    localparam int CON1_RDB_EN = 5;
    localparam int CON1_FDB_EN = 6;
    localparam int AS0_SHUT = 7;
    localparam int AS0_REN = 6;
    localparam int AS0_LSAC = 5;
    localparam int AS0_LSBD = 4;
    localparam int AS1_ASE = 7;
    // Mode encodings
    localparam logic [2:0] MODE_ASYNC = 3'h0;
    localparam logic [2:0] MODE_SYNC = 3'h1;
    localparam logic [2:0] MODE_FWD = 3'h2;
    localparam logic [2:0] MODE_REV = 3'h3;
    localparam logic [2:0] MODE_HB = 3'h4;
    localparam logic [2:0] MODE_PP = 3'h5;
    // Reset values and dead-band counter limit
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [6:0] DB_SAT = 7'h40;
endpackage

// ===== verilog/waveform_generator.sv
`timescale 1ns/1ps
// Contract
// - Half-bridge: A true, B complement, dead time
// - Half-bridge: C, D copy A, B
// - Push-pull alternates pulses between A and B
// - Alternation resets on disable or shutdown
// - Push-pull: C follows A, D follows B
// - Forward: A active, B C inactive, D modulated
// - Reverse: C active, A D inactive, B modulated
// - Direction toggle applied at next input rise
// - Static swap at once, modulated waits dead-band
// - Full-bridge dead time only on direction change
// - Steering: steered output modulated, else fixed level
// - Steering: polarity only on steered outputs
// - No dead-band in steering modes
// - Steering: shutdown overrides only steered outputs
// - Sync steering: steer bits load at rise
// - Sync steering: fixed levels act immediately
// - Async steering: steer bits act after write
// - Dead-band clock chosen by one select bit
// - Oscillator clock keeps dead-band running in sleep
// - Input source chosen by select field
// - Two 6-bit dead-band timers, own enables
// - Rise delays A, fall delays B
// - Dead-band 0 to 63 timer periods
// - Zero count no delay; reversal kills pulse
// - Shutdown level-held while input active, then until cleared by write or auto-restart
module waveform_generator
    import wave_gen_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] src_in,
    input wire logic [3:0] sd_in,
    input wire logic hf_tick,
    input wire logic sleep,
    output logic out_a,
    output logic out_b,
    output logic out_c,
    output logic out_d
);
    logic rst_s1_q, rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = wr && (a == b);
    endfunction

    logic [7:0] con0_q, con1_q, ism_q, dbr_q, dbf_q, str_reg_q, as0_q, as1_q, rdata_q;
    logic din_q, prev_q, shut_q, pp_q, dir_q;
    logic [3:0] str_q, out_q;
    logic [6:0] cr_q, cf_q, fb_q;

    wire en = con0_q[CON0_EN];
    wire [2:0] mode = con0_q[2:0];
    wire [3:0] pol = con1_q[3:0];
    wire [3:0] ovr = str_reg_q[7:4];
    wire hb = en && mode == MODE_HB;
    wire pp = en && mode == MODE_PP;
    wire fb = en && mode[2:1] == 2'b01;
    wire steer = mode[2:1] == 2'b00;
    wire sync_st = en && mode == MODE_SYNC;
    wire rise = din_q && !prev_q;
    wire fall = !din_q && prev_q;
    wire src_sel = src_in[ism_q[2:0]];
    // System clock stops in sleep; oscillator ticks keep going
    wire tick = con1_q[CON1_CS] ? hf_tick : !sleep;
    wire [6:0] dbr_eff = con1_q[CON1_RDB_EN] ? {1'b0, dbr_q[5:0]} : 7'h00;
    wire [6:0] dbf_eff = con1_q[CON1_FDB_EN] ? {1'b0, dbf_q[5:0]} : 7'h00;
    wire sd_hit = as1_q[AS1_ASE] && |(sd_in & as1_q[3:0]);
    wire sw_shut_wr = hit(addr, ADDR_AS0);

    // Full-bridge direction change, taken only at an input rise
    wire fb_chg = fb && rise && (mode[0] != dir_q);
    wire dir_eff = fb_chg ? mode[0] : dir_q;
    wire [6:0] fb_tgt = dir_eff ? dbr_eff : dbf_eff;
    wire fb_ok = !fb_chg && (fb_q >= fb_tgt);
    wire fb_mod = din_q && fb_ok;

    wire hb_a = din_q && (cr_q >= dbr_eff);
    wire hb_b = !din_q && (cf_q >= dbf_eff);
    wire pp_a = din_q && !pp_q;
    wire pp_b = din_q && pp_q;
    wire [3:0] str_eff = (mode == MODE_SYNC) ? str_q : str_reg_q[3:0];

    logic [3:0] raw, inv_ok, sd_mask;
    always_comb begin
        raw = 4'h0;
        inv_ok = 4'hf;
        sd_mask = 4'hf;
        case (mode)
            MODE_HB: raw = {hb_b, hb_a, hb_b, hb_a};
            MODE_PP: raw = {pp_b, pp_a, pp_b, pp_a};
            MODE_FWD, MODE_REV: begin
                if (!dir_eff) begin
                    raw = {fb_mod, 1'b0, 1'b0, 1'b1};
                end else begin
                    raw = {1'b0, 1'b1, fb_mod, 1'b0};
                end
            end
            MODE_ASYNC, MODE_SYNC: begin
                // Steered outputs see the raw input: no dead-band here
                raw = (str_eff & {4{din_q}}) | (~str_eff & ovr);
                inv_ok = str_eff;
                sd_mask = str_eff;
            end
            default: raw = 4'h0;
        endcase
    end

    wire [3:0] lvl = {as0_q[AS0_LSBD], as0_q[AS0_LSAC], as0_q[AS0_LSBD], as0_q[AS0_LSAC]};
    logic [3:0] out_nx;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            assign out_nx[gi] = !en ? 1'b0
                : (shut_q && sd_mask[gi]) ? lvl[gi]
                : raw[gi] ^ (pol[gi] && inv_ok[gi]);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            con0_q <= REG_RST;
            con1_q <= REG_RST;
            ism_q <= REG_RST;
            dbr_q <= REG_RST;
            dbf_q <= REG_RST;
            str_reg_q <= REG_RST;
            as1_q <= REG_RST;
            as0_q <= REG_RST;
        end else begin
            if (hit(addr, ADDR_CON0)) con0_q <= wdata;
            if (hit(addr, ADDR_CON1)) con1_q <= wdata;
            if (hit(addr, ADDR_ISM)) ism_q <= wdata;
            if (hit(addr, ADDR_DBR)) dbr_q <= wdata;
            if (hit(addr, ADDR_DBF)) dbf_q <= wdata;
            if (hit(addr, ADDR_STR)) str_reg_q <= wdata;
            if (hit(addr, ADDR_AS1)) as1_q <= wdata;
            if (sw_shut_wr) as0_q <= wdata;
        end
    end

    // Shutdown: set wins over every clear; held while an input stays active
    logic shut_d;
    always_comb begin
        shut_d = shut_q;
        if ((sw_shut_wr && !wdata[AS0_SHUT]) || (as0_q[AS0_REN] && rise)) begin
            shut_d = 1'b0;
        end
        if (sd_hit || (sw_shut_wr && wdata[AS0_SHUT])) begin
            shut_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_q <= 1'b0;
            din_q <= 1'b0;
            prev_q <= 1'b0;
            out_q <= 4'h0;
        end else begin
            shut_q <= shut_d;
            din_q <= src_sel;
            prev_q <= din_q;
            out_q <= out_nx;
        end
    end

    // Dead-band counters: restart at every input reversal
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_q <= 7'h00;
            cf_q <= 7'h00;
        end else begin
            if (!din_q) cr_q <= 7'h00;
            else if (tick && cr_q != DB_SAT) cr_q <= cr_q + 7'h01;
            if (din_q) cf_q <= 7'h00;
            else if (tick && cf_q != DB_SAT) cf_q <= cf_q + 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pp_q <= 1'b0;
        end else if (!en || shut_q) begin
            pp_q <= 1'b0;
        end else if (pp && fall) begin
            pp_q <= !pp_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= 1'b0;
            fb_q <= DB_SAT;
        end else if (!en) begin
            dir_q <= mode[0];
            fb_q <= DB_SAT;
        end else if (fb_chg) begin
            dir_q <= mode[0];
            fb_q <= 7'h00;
        end else if (tick && fb_q != DB_SAT) begin
            fb_q <= fb_q + 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            str_q <= 4'h0;
        end else if (!sync_st || rise) begin
            str_q <= str_reg_q[3:0];
        end
    end

    // Register read mux, answered the cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            ADDR_CON0: rd_mux = con0_q;
            ADDR_CON1: rd_mux = con1_q;
            ADDR_ISM: rd_mux = ism_q;
            ADDR_DBR: rd_mux = dbr_q;
            ADDR_DBF: rd_mux = dbf_q;
            ADDR_STR: rd_mux = str_reg_q;
            ADDR_AS0: rd_mux = {shut_q, as0_q[6:0]};
            ADDR_AS1: rd_mux = as1_q;
            ADDR_STAT: rd_mux = {2'b00, pp_q, dir_q, out_q};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rdata_q <= 8'h00;
        else rdata_q <= rd ? rd_mux : 8'h00;
    end

    assign rdata = rdata_q;
    assign out_a = out_q[0];
    assign out_b = out_q[1];
    assign out_c = out_q[2];
    assign out_d = out_q[3];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    hb_overlap_a: assert property (hb |-> !(raw[0] && raw[1]))
        else $error("half-bridge outputs overlap");
    hb_copy_a: assert property (hb |-> raw[2] == raw[0] && raw[3] == raw[1])
        else $error("half-bridge C or D differs");
    pp_alt_a: assert property (pp && fall && !shut_q |=> pp_q != $past(pp_q))
        else $error("push-pull did not alternate");
    pp_reset_a: assert property (!en || shut_q |=> !pp_q)
        else $error("push-pull sequencer not reset");
    fb_fwd_a: assert property (fb && !dir_eff |-> raw[0] && !raw[1] && !raw[2])
        else $error("forward static outputs wrong");
    fb_swap_a: assert property (fb_chg |-> !raw[1] && !raw[3] ##1 dir_q == $past(mode[0]))
        else $error("direction change not handled");
    steer_fix_a: assert property (en && steer && !str_eff[0] && !shut_q |=> out_a == $past(ovr[0]))
        else $error("fixed level not held");
    sync_hold_a: assert property (sync_st && !rise |=> str_q == $past(str_q))
        else $error("sync steer changed off edge");
    shut_hold_a: assert property (sd_hit |=> shut_q [*2])
        else $error("shutdown released while input held");
    db_zero_a: assert property (hb && rise && dbr_eff == 7'h00 |-> raw[0])
        else $error("zero dead band delayed");

    // Per-mode output shaping
    dis_zero_a: assert property (!en |=> out_q == 4'h0)
        else $error("outputs active while disabled");

    hb_b_comp_a: assert property (hb && !din_q && cf_q >= dbf_eff |-> raw[1])
        else $error("half-bridge B missing");

    hb_a_delay_a: assert property (hb && din_q && cr_q < dbr_eff |-> !raw[0])
        else $error("half-bridge A early");

    hb_b_delay_a: assert property (hb && !din_q && cf_q < dbf_eff |-> !raw[1])
        else $error("half-bridge B early");

    db_kill_a: assert property (hb && !din_q |-> !raw[0])
        else $error("A active after input fall");

    pp_excl_a: assert property (pp |-> !(raw[0] && raw[1]))
        else $error("push-pull A and B together");

    pp_copy_a: assert property (pp |-> raw[2] == raw[0] && raw[3] == raw[1])
        else $error("push-pull C or D differs");

    pp_first_a: assert property (pp && !pp_q && din_q |-> raw[0])
        else $error("push-pull first pulse not on A");

    fb_rev_a: assert property (fb && dir_eff |-> raw[2] && !raw[0] && !raw[3])
        else $error("reverse static outputs wrong");

    fb_dmod_a: assert property (fb && !dir_eff |-> raw[3] == fb_mod)
        else $error("forward D not modulated");

    fb_bmod_a: assert property (fb && dir_eff |-> raw[1] == fb_mod)
        else $error("reverse B not modulated");

    fb_hold_a: assert property (fb && !rise |=> dir_q == $past(dir_q))
        else $error("direction changed off rise");

    fb_wait_a: assert property (fb && !fb_chg && fb_q < fb_tgt |-> !fb_mod)
        else $error("modulation before dead band");

    fb_steady_a: assert property (fb && !fb_chg && fb_q == DB_SAT |-> fb_mod == din_q)
        else $error("steady full-bridge delayed");

    steer_mod_a: assert property (en && steer && str_eff[0] |-> raw[0] == din_q)
        else $error("steered output not modulated");

    steer_pol_a: assert property (en && steer && !str_eff[1] && !shut_q |-> out_nx[1] == ovr[1])
        else $error("fixed level inverted");

    steer_nodb_a: assert property (en && steer && str_eff[3] && !shut_q |-> out_nx[3] == (din_q ^ pol[3]))
        else $error("steered output delayed");

    steer_sd_a: assert property (en && steer && shut_q && !str_eff[2] |-> out_nx[2] == ovr[2])
        else $error("shutdown hit unsteered output");

    sync_load_a: assert property (sync_st && rise |=> str_q == $past(str_reg_q[3:0]))
        else $error("sync steer not loaded at rise");

    sync_ovr_a: assert property (sync_st && !str_eff[0] |-> raw[0] == ovr[0])
        else $error("fixed level deferred");

    async_str_a: assert property (en && mode == MODE_ASYNC |-> str_eff == str_reg_q[3:0])
        else $error("async steer deferred");

    // Dead-band timing base and limits, shutdown and register access
    tick_sel_a: assert property (con1_q[CON1_CS] |-> tick == hf_tick)
        else $error("oscillator tick not used");

    sleep_stop_a: assert property (!con1_q[CON1_CS] && sleep |-> !tick)
        else $error("system clock ticks in sleep");

    db_off_a: assert property (!con1_q[CON1_RDB_EN] |-> dbr_eff == 7'h00)
        else $error("disabled dead band applied");

    db_sat_a: assert property (cr_q <= DB_SAT && cf_q <= DB_SAT && fb_q <= DB_SAT)
        else $error("dead-band counter overrun");

    shut_set_a: assert property (sd_hit |=> shut_q)
        else $error("shutdown input ignored");

    shut_lvl_a: assert property (en && !steer && shut_q |-> out_nx == lvl)
        else $error("override level wrong");

    wr_land_a: assert property (hit(addr, ADDR_CON0) |=> con0_q == $past(wdata))
        else $error("control write lost");

    rd_idle_a: assert property (!rd |=> rdata_q == 8'h00)
        else $error("read data outside read cycle");

    pp_alt_c: cover property (pp && fall);
    shut_c: cover property (sd_hit ##1 shut_q);

    fb_change_c: cover property (fb_chg ##[1:100] fb_mod);
    hb_run_c: cover property (hb && rise ##[1:100] fall);
    steer_shut_c: cover property (en && steer && shut_q && str_eff != 4'hf);
endmodule

// ===== dv/gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
    input wire logic clk,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic arm,
    output int n_a,
    output logic shoot_q
);
    logic a_q = 1'b0;
    initial begin
        n_a = 0;
        shoot_q = 1'b0;
    end
    // High-side turn-on count and shoot-through watch on the A/B leg
    always @(posedge clk) begin
        a_q <= out_a;
        if (out_a && !a_q)
            n_a <= n_a + 1;
        if (arm && out_a && out_b)
            shoot_q <= 1'b1;
    end
endmodule

// ===== dv/test_waveform_generator.sv
`timescale 1ns/1ps
module test_waveform_generator;
    import wave_gen_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] src_in = 8'hf7;
    logic [3:0] sd_in = 4'h0;
    logic hf_tick = 1'b0;
    logic sleep = 1'b0;
    logic out_a;
    logic out_b;
    logic out_c;
    logic out_d;
    logic arm = 1'b0;
    logic shoot_q;
    int n_a;
    int na;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) hf_tick <= ~hf_tick;

    waveform_generator dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_in(src_in), .sd_in(sd_in), .hf_tick(hf_tick), .sleep(sleep),
        .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));
    gate_driver_model drv (.clk(clk), .out_a(out_a), .out_b(out_b), .arm(arm), .n_a(n_a), .shoot_q(shoot_q));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(rdata, e);
    endtask
    // Selected source is bit 3; the other bits carry the opposite level
    task automatic srcv(input logic v);
        @(posedge clk);
        src_in <= v ? 8'h08 : 8'hf7;
    endtask
    task automatic outs(input int n, input logic [3:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        cmp({4'h0, out_a, out_b, out_c, out_d}, {4'h0, e});
    endtask

    task automatic t_regs;
        rchk(ADDR_CON0, REG_RST);
        wreg(ADDR_DBR, 8'h3f);
        rchk(ADDR_DBR, 8'h3f);
        rchk(4'hf, 8'h00);
        wreg(ADDR_ISM, 8'h03);
        $display("regs done");
    endtask
    task automatic t_half;
        arm <= 1'b1;
        wreg(ADDR_CON1, 8'h64);
        wreg(ADDR_DBR, 8'h04);
        wreg(ADDR_DBF, 8'h04);
        wreg(ADDR_CON0, {5'h10, MODE_HB});
        outs(4, 4'h7);
        srcv(1'b1);
        outs(3, 4'h2);
        outs(8, 4'h8);
        srcv(1'b0);
        outs(3, 4'h2);
        outs(8, 4'h7);
        na = n_a;
        srcv(1'b1);
        repeat (2) @(posedge clk);
        srcv(1'b0);
        outs(10, 4'h7);
        cmp(n_a[7:0], na[7:0]);
        wreg(ADDR_CON1, 8'h44);
        srcv(1'b1);
        outs(3, 4'h8);
        srcv(1'b0);
        outs(3, 4'h2);
        wreg(ADDR_CON0, 8'h00);
        $display("half bridge done");
    endtask
    task automatic t_push;
        wreg(ADDR_CON1, 8'h00);
        wreg(ADDR_CON0, {5'h10, MODE_PP});
        srcv(1'b1);
        outs(4, 4'ha);
        srcv(1'b0);
        outs(4, 4'h0);
        srcv(1'b1);
        outs(4, 4'h5);
        srcv(1'b0);
        wreg(ADDR_CON0, 8'h00);
        wreg(ADDR_CON0, {5'h10, MODE_PP});
        srcv(1'b1);
        outs(4, 4'ha);
        srcv(1'b0);
        wreg(ADDR_CON0, 8'h00);
        $display("push pull done");
    endtask
    task automatic t_full;
        wreg(ADDR_CON1, 8'h60);
        wreg(ADDR_DBR, 8'h06);
        wreg(ADDR_DBF, 8'h06);
        wreg(ADDR_CON0, {5'h10, MODE_FWD});
        outs(4, 4'h8);
        srcv(1'b1);
        outs(3, 4'h9);
        wreg(ADDR_CON0, {5'h10, MODE_REV});
        outs(2, 4'h9);
        srcv(1'b0);
        outs(3, 4'h8);
        srcv(1'b1);
        outs(3, 4'h2);
        outs(10, 4'h6);
        rchk(ADDR_STAT, 8'h16);
        srcv(1'b0);
        outs(3, 4'h2);
        srcv(1'b1);
        outs(3, 4'h6);
        wreg(ADDR_CON0, 8'h00);
        $display("full bridge done");
    endtask
    task automatic t_steer;
        arm <= 1'b0;
        srcv(1'b0);
        wreg(ADDR_CON1, 8'h01);
        wreg(ADDR_STR, 8'hc1);
        wreg(ADDR_CON0, {5'h10, MODE_SYNC});
        srcv(1'b1);
        outs(3, 4'h3);
        srcv(1'b0);
        outs(3, 4'hb);
        wreg(ADDR_STR, 8'h42);
        outs(2, 4'ha);
        srcv(1'b1);
        outs(3, 4'h6);
        wreg(ADDR_CON0, 8'h00);
        wreg(ADDR_CON0, {5'h10, MODE_ASYNC});
        wreg(ADDR_STR, 8'h08);
        outs(2, 4'h1);
        wreg(ADDR_STR, 8'h48);
        wreg(ADDR_AS0, 8'h00);
        wreg(ADDR_AS1, 8'h81);
        @(posedge clk);
        sd_in <= 4'h1;
        outs(4, 4'h2);
        wreg(ADDR_AS0, 8'h00);
        outs(2, 4'h2);
        @(posedge clk);
        sd_in <= 4'h0;
        wreg(ADDR_AS0, 8'h00);
        outs(3, 4'h3);
        wreg(ADDR_CON0, 8'h00);
        outs(2, 4'h0);
        $display("steering done");
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_half();
        t_push();
        t_full();
        t_steer();
        cmp({7'h0, shoot_q}, 8'h00);
        report_and_stop();
    end
endmodule
